// ===== adc_core_ctrl.sv
// Purpose: clock, enable, power-up and input control of converter cores
// Assumes: source ticks and triggers are pulses on CLK_SYS_I
// Notes: cores 0..3 are dedicated, index 4 is the shared core
//
// What this block does
// - two-bit code picks module clock source
// - module clock divided by field plus one
// - one core source clock, per-core dividers
// - shared core enabled by bit 7
// - bits 3..0 enable dedicated cores
// - delay enabled keeps sampling for delay
// - delay disabled converts on next core clock
// - delay counts field plus two core clocks
// - core 3 selects input 3 or 15
// - core 2 selects 2, 11 or band-gap
// - core 1 selects 1, 18, amp two, alt
// - core 0 selects 0, 7, amp one, alt
// - differential mode makes code 01 negative input
// - shared core powered by bit 7
// - dedicated cores powered by bits 3..0
// - read-only ready flags per core
// - one power-up delay, 16 to 32768
// - shared ready raises common interrupt if enabled
// - dedicated ready raises interrupt if enabled
// - unimplemented bits ignore writes, read zero
// - core divider 2 periods, doubling code, 254
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "adc_core_ctrl_map.svh"

module adc_core_ctrl #(
   parameter int ADDR_W = 4
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   input wire logic AUX_PLL_TICK_I,
   input wire logic FAST_RC_TICK_I,
   input wire logic [3:0] TRIG_I,
   output logic CORE_SRC_TICK_O,
   output logic [4:0] CORE_TICK_O,
   output logic [4:0] CORE_ENABLE_O,
   output logic [4:0] CORE_POWER_O,
   output logic [4:0] CORE_READY_O,
   output logic [3:0] SAMPLING_O,
   output logic [3:0] CONV_START_O,
   output logic [23:0] CORE_CHANNEL_O,
   output logic [3:0] DIFF_NEG_O,
   output logic READY_IRQ_O
);

   // Address must reach every register index
   if (ADDR_W < 4) begin : g_addr_check
      $error("ADDR_W must be at least 4");
   end

   // Registered and next state
   adc_core_ctrl_pkg::state_t q;
   adc_core_ctrl_pkg::state_t d;

   // Spread a five-core vector onto the register layout
   function automatic logic [7:0] pack5(input logic [4:0] v);
      pack5 = {v[4], 3'h0, v[3:0]};
   endfunction : pack5

   // Collect a five-core vector from a register byte
   function automatic logic [4:0] unpack5(input logic [7:0] b);
      unpack5 = {b[`SHR_BIT], b[3:0]};
   endfunction : unpack5

   // Power-up delay in core source periods
   function automatic logic [15:0] warm_limit(input logic [3:0] code);
      logic [3:0] sh;
      sh = 4'h0;
      if (code >= `WARM_SHIFT_BASE) begin
         sh = code - `WARM_SHIFT_BASE;
      end
      warm_limit = `WARM_MIN << sh;
   endfunction : warm_limit

   // Last count of a core divider, ratio minus one
   function automatic logic [7:0] div_last(input logic [6:0] code);
      logic [7:0] r;
      r = 8'h02;
      if (code > 7'h01) begin
         r = {code, 1'b0};
      end
      div_last = r - 8'h01;
   endfunction : div_last

   // Input selection code to channel number
   function automatic logic [5:0] chan(input logic [1:0] core, input logic [1:0] sel);
      logic [5:0] c;
      c = `CH_NONE;
      unique case (core)
         2'h3: begin
            if (sel == 2'h0) c = 6'h03;
            else if (sel == 2'h1) c = 6'h0F;
         end
         2'h2: begin
            if (sel == 2'h0) c = 6'h02;
            else if (sel == 2'h1) c = 6'h0B;
            else if (sel == 2'h2) c = `CH_BANDGAP;
         end
         2'h1: begin
            if (sel == 2'h0) c = 6'h01;
            else if (sel == 2'h1) c = 6'h12;
            else if (sel == 2'h2) c = `CH_GAIN_TWO;
            else c = `CH_ALT_ONE;
         end
         2'h0: begin
            if (sel == 2'h0) c = 6'h00;
            else if (sel == 2'h1) c = 6'h07;
            else if (sel == 2'h2) c = `CH_GAIN_ONE;
            else c = `CH_ALT_ZERO;
         end
      endcase
      chan = c;
   endfunction : chan

   // Next-state logic
   always_comb begin
      logic src_pulse;
      logic [4:0] ready_rise;
      logic [3:0] widx;
      d = q;
      src_pulse = 1'b0;
      ready_rise = 5'h0;
      widx = ADDR_I[3:0];
      d.conv_start = 4'h0;
      d.src_tick = 1'b0;
      d.core_tick = 5'h0;

      // Register writes; only implemented bits are stored
      if (WR_I && ADDR_I < ADDR_W'(11)) begin
         unique case (widx)
            `RIDX_CLK_EN: begin
               d.clk_sel = WDATA_I[`CLK_SEL_LSB +: 2];
               d.clk_div = WDATA_I[`CLK_DIV_LSB +: 6];
               d.core_en = unpack5(WDATA_I[7:0]);
            end
            `RIDX_DLY_EN: d.dly_en = WDATA_I[3:0];
            `RIDX_IN_SEL: d.in_sel = WDATA_I[7:0];
            `RIDX_PWR_READY: begin
               d.pwr = unpack5(WDATA_I[7:0]);
            end
            `RIDX_WARM_IRQ: begin
               d.warm_sel = WDATA_I[`WARM_LSB +: 4];
               d.irq_en = unpack5(WDATA_I[7:0]);
            end
            `RIDX_SHR_DIV: d.core_div[4] = WDATA_I[`CORE_DIV_LSB +: 7];
            `RIDX_MODE: d.diff = {WDATA_I[7], WDATA_I[5], WDATA_I[3], WDATA_I[1]};
            default: begin
               // Per dedicated core delay and divider
               d.conv_dly[widx[1:0] - 2'h1] = WDATA_I[9:0];
               d.core_div[widx[1:0] - 2'h1] = WDATA_I[`CORE_DIV_LSB +: 7];
            end
         endcase
      end

      unique case (q.clk_sel)
         `SRC_AUX_PLL: src_pulse = AUX_PLL_TICK_I;
         `SRC_FAST_RC: src_pulse = FAST_RC_TICK_I;
         // Double rate cannot beat one tick per cycle
         `SRC_SYS_X2: src_pulse = 1'b1;
         `SRC_SYS: src_pulse = 1'b1;
      endcase

      if (src_pulse) begin
         if (q.mod_cnt >= q.clk_div) begin
            d.mod_cnt = 6'h00;
            d.src_tick = 1'b1;
         end else begin
            d.mod_cnt = q.mod_cnt + 6'h01;
         end
      end

      // Per core dividers, warm-up and ready
      for (int i = 0; i < 5; i++) begin
         // every core runs off the source tick
         // ratio 2 or twice the code
         if (!q.core_en[i]) begin
            d.div_cnt[i] = 8'h00;
         end else if (q.src_tick) begin
            if (q.div_cnt[i] >= div_last(q.core_div[i])) begin
               d.div_cnt[i] = 8'h00;
               d.core_tick[i] = 1'b1;
            end else begin
               d.div_cnt[i] = q.div_cnt[i] + 8'h01;
            end
         end

         // power off clears ready at once
         if (!q.pwr[i]) begin
            d.warm_cnt[i] = 16'h0000;
            d.ready[i] = 1'b0;
         end else if (!q.ready[i] && q.src_tick) begin
            d.warm_cnt[i] = q.warm_cnt[i] + 16'h0001;
            if (d.warm_cnt[i] >= warm_limit(q.warm_sel)) begin
               d.ready[i] = 1'b1;
            end
         end
      end

      // Conversion sequencers, dedicated cores only
      for (int i = 0; i < 4; i++) begin
         if (!q.core_en[i] || !q.ready[i]) begin
            // Disabled or cold core ignores triggers
            d.cst[i] = adc_core_ctrl_pkg::CONV_IDLE;
            d.conv_cnt[i] = 11'h000;
         end else begin
            unique case (q.cst[i])
               adc_core_ctrl_pkg::CONV_IDLE: begin
                  if (TRIG_I[i]) begin
                     d.conv_cnt[i] = 11'h000;
                     // delay enabled keeps sampling, else stop now, convert on next tick
                     if (q.dly_en[i]) d.cst[i] = adc_core_ctrl_pkg::CONV_DELAY;
                     else d.cst[i] = adc_core_ctrl_pkg::CONV_NEXT;
                  end
               end
               adc_core_ctrl_pkg::CONV_DELAY: begin
                  if (q.core_tick[i]) begin
                     if (q.conv_cnt[i] >= {1'b0, q.conv_dly[i]} + 11'h001) begin
                        d.conv_start[i] = 1'b1;
                        d.cst[i] = adc_core_ctrl_pkg::CONV_IDLE;
                     end else begin
                        d.conv_cnt[i] = q.conv_cnt[i] + 11'h001;
                     end
                  end
               end
               adc_core_ctrl_pkg::CONV_NEXT: begin
                  if (q.core_tick[i]) begin
                     d.conv_start[i] = 1'b1;
                     d.cst[i] = adc_core_ctrl_pkg::CONV_IDLE;
                  end
               end
            endcase
         end
      end

      // ready events of all five cores gated by their enables
      ready_rise = d.ready & ~q.ready;
      d.irq = |(ready_rise & q.irq_en);

      // Read data one cycle after the strobe
      d.rdata = 32'h0000_0000;
      if (RD_I && ADDR_I < ADDR_W'(11)) begin
         unique case (widx)
            `RIDX_CLK_EN: d.rdata = {16'h0000, q.clk_sel, q.clk_div, pack5(q.core_en)};
            `RIDX_DLY_EN: d.rdata = {28'h0000000, q.dly_en};
            `RIDX_IN_SEL: d.rdata = {24'h000000, q.in_sel};
            `RIDX_PWR_READY: d.rdata = {16'h0000, pack5(q.ready), pack5(q.pwr)};
            `RIDX_WARM_IRQ: d.rdata = {20'h00000, q.warm_sel, pack5(q.irq_en)};
            `RIDX_SHR_DIV: d.rdata = {9'h000, q.core_div[4], 16'h0000};
            `RIDX_MODE: d.rdata = {24'h000000, q.diff[3], 1'b0, q.diff[2], 1'b0,
                                   q.diff[1], 1'b0, q.diff[0], 1'b0};
            default: d.rdata = {9'h000, q.core_div[widx[1:0] - 2'h1], 6'h00,
                                q.conv_dly[widx[1:0] - 2'h1]};
         endcase
      end
   end

   // State register, synchronous reset to all zero
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs
   assign RDATA_O = q.rdata;
   assign CORE_SRC_TICK_O = q.src_tick;
   assign CORE_TICK_O = q.core_tick;
   assign CORE_ENABLE_O = q.core_en;
   assign CORE_POWER_O = q.pwr;
   assign CORE_READY_O = q.ready;
   assign CONV_START_O = q.conv_start;
   assign READY_IRQ_O = q.irq;

   // Per dedicated core sampling, channel and differential flag
   for (genvar g = 0; g < 4; g++) begin : g_core
      // sampling spans idle and delay phases
      assign SAMPLING_O[g] = q.core_en[g] & q.ready[g] &
                             (q.cst[g] != adc_core_ctrl_pkg::CONV_NEXT);
      assign CORE_CHANNEL_O[6*g +: 6] = chan(2'(g), q.in_sel[2*g +: 2]);
      // code 01 becomes the negative input
      assign DIFF_NEG_O[g] = q.diff[g] & (q.in_sel[2*g +: 2] == 2'h1);
   end

endmodule : adc_core_ctrl

// ===== adc_core_ctrl_assertions.sv
// Purpose: port checks of the core control block
// Assumes: read data one cycle after the read strobe
// Notes: bound to the design below
`timescale 1ns/1ps
module adc_core_ctrl_assertions #(
   parameter int ADDR_W = 4
) (
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic RD_I,
   input wire logic [31:0] RDATA_O,
   input wire logic [4:0] CORE_ENABLE_O,
   input wire logic [4:0] CORE_POWER_O,
   input wire logic [4:0] CORE_READY_O,
   input wire logic [3:0] CONV_START_O,
   input wire logic [23:0] CORE_CHANNEL_O,
   input wire logic [3:0] DIFF_NEG_O,
   input wire logic READY_IRQ_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   // Read strobe at one index
   sequence rd_at(logic [ADDR_W-1:0] a);
      RD_I && ADDR_I == a;
   endsequence
   a_status_map: assert property (rd_at(4'h3) |=> RDATA_O == {16'h0000, $past(CORE_READY_O[4]), 3'h0,
      $past(CORE_READY_O[3:0]), $past(CORE_POWER_O[4]), 3'h0, $past(CORE_POWER_O[3:0])}) else $error("bad status");
   a_enable_map: assert property (rd_at(4'h0) |=> RDATA_O[7:0] == {$past(CORE_ENABLE_O[4]), 3'h0,
      $past(CORE_ENABLE_O[3:0])} && RDATA_O[31:16] == 16'h0000) else $error("bad enables");
   a_unmapped_zero: assert property (RD_I && ADDR_I > 10 |=> RDATA_O == 32'h0) else $error("unmapped");
   a_ready_power: assert property ((CORE_READY_O & ~$past(CORE_POWER_O)) == 5'h00) else $error("rdy");
   // Pulse and ready flag leave the same edge, so the rise is seen with the pulse
   a_irq_cause: assert property (READY_IRQ_O |-> |(CORE_READY_O & ~$past(CORE_READY_O))) else $error("stray irq");
   a_start_pulse: assert property ((CONV_START_O & $past(CONV_START_O)) == 4'h0) else $error("start");
   a_core3_chan: assert property (CORE_CHANNEL_O[23:18] inside {6'h03, 6'h0F, 6'h3F}) else $error("ch3");
   a_core2_chan: assert property (CORE_CHANNEL_O[17:12] inside {6'h02, 6'h0B, 6'h20, 6'h3F}) else $error("ch2");
   a_core1_chan: assert property (CORE_CHANNEL_O[11:6] inside {6'h01, 6'h12, 6'h22, 6'h24}) else $error("ch1");
   a_diff_neg: assert property (DIFF_NEG_O[3] |-> CORE_CHANNEL_O[23:18] == 6'h0F) else $error("diff");
endmodule : adc_core_ctrl_assertions

bind adc_core_ctrl adc_core_ctrl_assertions #(.ADDR_W(ADDR_W)) u_chk (.CLK_SYS_I, .RST_N_I, .ADDR_I, .RD_I,
   .RDATA_O, .CORE_ENABLE_O, .CORE_POWER_O, .CORE_READY_O, .CONV_START_O, .CORE_CHANNEL_O, .DIFF_NEG_O,
   .READY_IRQ_O);

// ===== adc_core_ctrl_bench.sv
// Purpose: self-checking bench of the core control block
// Assumes: 125 MHz clock, read data one cycle after the strobe
// Notes: small dividers keep warm-up and delays short
`timescale 1ns/1ps
`include "adc_core_ctrl_map.svh"
module adc_core_ctrl_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [3:0] trig = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic aux, rc, src, irq;
   logic [4:0] tick, en, pwr, rdy;
   logic [3:0] samp, start, dneg;
   logic [23:0] chan;
   int mismatches = 0, checks_done = 0, cyc = 0, irqs = 0, n;
   // Readback after writing all ones; index 11 is unmapped
   logic [31:0] mask [12] = '{32'h0000FF8F, 32'hF, 32'hFF, 32'h8F, 32'hF8F, 32'h7F03FF, 32'h7F03FF,
      32'h7F03FF, 32'h7F03FF, 32'h7F0000, 32'hAA, 32'h0};
   // Channel codes of the four dedicated cores per select code
   logic [23:0] chx [4] = '{24'h0C2040, 24'h3CB487, 24'hFE08A1, 24'hFFF923};
   logic [31:0] srcv [4] = '{32'hC000, 32'h8100, 32'h4000, 32'h0200};
   int srcp [4] = '{3, 10, 1, 3};
   adc_core_ctrl DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .AUX_PLL_TICK_I(aux), .FAST_RC_TICK_I(rc), .TRIG_I(trig),
      .CORE_SRC_TICK_O(src), .CORE_TICK_O(tick), .CORE_ENABLE_O(en), .CORE_POWER_O(pwr),
      .CORE_READY_O(rdy), .SAMPLING_O(samp), .CONV_START_O(start), .CORE_CHANNEL_O(chan),
      .DIFF_NEG_O(dneg), .READY_IRQ_O(irq));
   adc_src_model #(.AUX_P(3), .RC_P(5)) u_src (.clk_i(clk), .aux_o(aux), .rc_o(rc));
   always #4 clk = ~clk;
   // Interrupt pulses and the hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (irq === 1'b1) irqs <= irqs + 1;
      if (cyc == 5000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic nxt;
      @(posedge clk);
      #1;
   endtask : nxt
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      got = rdata;
   endtask : rd_reg
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic rng(input string nm, input int lo, input int hi, input int v);
      checks_done++;
      if (v < lo || v > hi) begin
         mismatches++;
         $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, v);
      end
   endtask : rng
   // Wait for a ready flag, bounded
   task automatic wait_rdy(input int b);
      n = 0;
      while (rdy[b] !== 1'b1 && n < 300) begin
         nxt;
         n++;
      end
   endtask : wait_rdy
   // Trigger core 0, count cycles to its start
   task automatic fire;
      @(posedge clk);
      trig <= 4'h1;
      @(posedge clk);
      trig <= 4'h0;
      #1;
      got = 32'(samp[0]);
      n = 0;
      while (start[0] !== 1'b1 && n < 100) begin
         nxt;
         n++;
      end
   endtask : fire
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         rd_reg(4'(i));
         chk("reset", 32'h0, got);
         wr_reg(4'(i), 32'hFFFFFFFF);
         rd_reg(4'(i));
         chk("mask", mask[i], got);
         wr_reg(4'(i), 32'h0);
      end
      $display("test registers done");
      wr_reg(`RIDX_MODE, 32'hAA);
      for (int c = 0; c < 4; c++) begin
         wr_reg(`RIDX_IN_SEL, 32'(c) * 32'h55);
         nxt;
         chk("channel", 32'(chx[c]), 32'(chan));
         chk("diffneg", (c == 1) ? 32'hF : 32'h0, 32'(dneg));
      end
      $display("test inputs done");
      for (int s = 0; s < 4; s++) begin
         wr_reg(`RIDX_CLK_EN, srcv[s]);
         repeat (25) nxt;
         n = 0;
         while (src !== 1'b1 && n < 400) begin
            nxt;
            n++;
         end
         n = 0;
         do begin
            nxt;
            n++;
         end while (src !== 1'b1 && n < 50);
         rng("srcperiod", srcp[s], srcp[s], n);
      end
      wr_reg(`RIDX_CLK_EN, 32'h18F);
      nxt;
      chk("enable", 32'h1F, 32'(en));
      // Shared core divider code 0 is two source ticks of two cycles each
      n = 0;
      while (tick[4] !== 1'b1 && n < 50) begin
         nxt;
         n++;
      end
      n = 0;
      do begin
         nxt;
         n++;
      end while (tick[4] !== 1'b1 && n < 50);
      rng("coretick", 4, 4, n);
      $display("test clocks done");
      wr_reg(`RIDX_WARM_IRQ, 32'h581);
      wr_reg(`RIDX_PWR_READY, 32'h2);
      wait_rdy(1);
      rng("warmup", 60, 70, n);
      chk("masked", 32'h0, 32'(irqs));
      wr_reg(`RIDX_PWR_READY, 32'h3);
      wait_rdy(0);
      repeat (2) nxt;
      chk("coreirq", 32'h1, 32'(irqs));
      wr_reg(`RIDX_PWR_READY, 32'h83);
      wait_rdy(4);
      repeat (2) nxt;
      chk("sharedirq", 32'h2, 32'(irqs));
      rd_reg(`RIDX_PWR_READY);
      chk("status", 32'h8383, got);
      wr_reg(`RIDX_PWR_READY, 32'h81);
      repeat (2) nxt;
      chk("power", 32'h11, 32'(pwr));
      chk("ready", 32'h11, 32'(rdy));
      $display("test power done");
      fire;
      chk("sampoff", 32'h0, got);
      rng("nodelay", 1, 6, n);
      wr_reg(`RIDX_DLY_EN, 32'h1);
      wr_reg(`RIDX_CORE_BASE, 32'h3);
      fire;
      chk("sampon", 32'h1, got);
      rng("delay", 16, 26, n);
      $display("test trigger done");
      close_out();
   end
endmodule : adc_core_ctrl_bench

// ===== adc_core_ctrl_map.svh
// Purpose: offsets, field positions and codes of the core control block
// Assumes: 32-bit register port, word index addressing
// Notes: definitions only
`ifndef ADC_CORE_CTRL_MAP_SVH
`define ADC_CORE_CTRL_MAP_SVH

// Register word indexes
`define RIDX_CLK_EN 4'h0
`define RIDX_DLY_EN 4'h1
`define RIDX_IN_SEL 4'h2
`define RIDX_PWR_READY 4'h3
`define RIDX_WARM_IRQ 4'h4
`define RIDX_CORE_BASE 4'h5
`define RIDX_SHR_DIV 4'h9
`define RIDX_MODE 4'hA

// Field positions
`define SHR_BIT 7
`define SHR_READY_BIT 15
`define READY_LSB 8
`define CLK_SEL_LSB 14
`define CLK_DIV_LSB 8
`define WARM_LSB 8
`define CORE_DIV_LSB 16

// Module clock sources
`define SRC_AUX_PLL 2'h3
`define SRC_FAST_RC 2'h2
`define SRC_SYS_X2 2'h1
`define SRC_SYS 2'h0

// Channel codes on the core input outputs
`define CH_BANDGAP 6'h20
`define CH_GAIN_ONE 6'h21
`define CH_GAIN_TWO 6'h22
`define CH_ALT_ZERO 6'h23
`define CH_ALT_ONE 6'h24
`define CH_NONE 6'h3F

// Power-up delay
`define WARM_MIN 16'h0010
`define WARM_SHIFT_BASE 4'h4

`endif

// ===== adc_core_ctrl_pkg.sv
// Purpose: types of the core control block
// Assumes: four dedicated cores plus one shared core at index 4
// Notes: constants live in adc_core_ctrl_map.svh
package adc_core_ctrl_pkg;

   // Per dedicated core conversion sequencer
   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_DELAY,
      CONV_NEXT
   } conv_state_t;

   // Whole state of the block
   typedef struct packed {
      logic [1:0] clk_sel;
      logic [5:0] clk_div;
      logic [4:0] core_en;
      logic [3:0] dly_en;
      logic [7:0] in_sel;
      logic [4:0] pwr;
      logic [4:0] ready;
      logic [3:0] warm_sel;
      logic [4:0] irq_en;
      logic [3:0] diff;
      logic [3:0][9:0] conv_dly;
      logic [4:0][6:0] core_div;
      logic [5:0] mod_cnt;
      logic src_tick;
      logic [4:0][7:0] div_cnt;
      logic [4:0] core_tick;
      logic [4:0][15:0] warm_cnt;
      logic [3:0][10:0] conv_cnt;
      conv_state_t [3:0] cst;
      logic [3:0] conv_start;
      logic irq;
      logic [31:0] rdata;
   } state_t;

endpackage : adc_core_ctrl_pkg

// ===== adc_src_model.sv
// Purpose: oscillators on the far side of the block
// Assumes: each tick is one system cycle long
// Notes: periods are arbitrary test values
`timescale 1ns/1ps
module adc_src_model #(
   parameter int AUX_P = 3,
   parameter int RC_P = 5
) (
   input wire logic clk_i,
   output logic aux_o,
   output logic rc_o
);
   int cnt = 0; // Free-running cycle count
   // Pulses derived from the count, so defined at time zero
   assign aux_o = (cnt % AUX_P) == 0;
   assign rc_o = (cnt % RC_P) == 0;
   always @(posedge clk_i) begin
      cnt <= cnt + 1;
   end
endmodule : adc_src_model
